// ==== tx_clock_phase_align.sv ====
// transmit clock selection, phase align buffer and transmit clock output
// Notes on behaviour
// - reference clock times the transmit character clock.
// - reference clock may be chosen as the parallel interface clock.
// - source select 0 uses the host input clock to capture characters.
// - drift up to two characters either way is absorbed; host keeps within it.
// - drift beyond buffer capacity raises the path error until reinit or a word sync.
// - writing the reinit bit as 0 recentres the phase align buffer.
// - path error low means the buffer is initialized and capture is good.
// - transmit clock output follows the internal transmit character clock.
// - output rate select 0 gives reference rate, 1 gives twice that.
// - no fixed phase between transmit clock output and reference clock.
// - half-rate mode samples reference-timed inputs on both edges.
// - half-rate mode updates reference-timed outputs on both edges.
// - characters are captured on the selected interface clock rising edge; with the reference selected, half-rate mode adds its falling edge.
// - path error clears on buffer recentring, and after a slip also on a word sync.
module tx_clock_phase_align (
   input  wire logic                          clock_in,
   input  wire logic                          rst_in,
   input  wire logic                          ref_clock_in,
   input  wire logic                          tx_input_clock,
   input  wire logic [7:0]                    tx_char_in,
   input  wire logic [1:0]                    tx_char_ctrl,
   input  wire logic [tx_align_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [tx_align_pkg::DATA_W-1:0] wdata_in,
   input  wire logic                          wr_in,
   input  wire logic                          rd_in,
   output logic      [tx_align_pkg::DATA_W-1:0] rdata_out,
   output tx_align_pkg::tx_char_s             char_out,
   output logic                               char_valid_out,
   output logic                               tx_clock_out,
   output logic                               tx_path_error_out,
   output logic                               irq_out
);
   import tx_align_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] ref_sync_q;
   logic [1:0] txc_sync_q;
   logic       ref_prev_q;
   logic       txc_prev_q;
   tx_char_s   pin_meta_q;
   tx_char_s   pin_sync_q;

   // two flops per pin; only the second stage is read
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ref_sync_q <= 2'h0;
         txc_sync_q <= 2'h0;
         ref_prev_q <= 1'b0;
         txc_prev_q <= 1'b0;
         pin_meta_q <= CHAR_RST;
         pin_sync_q <= CHAR_RST;
      end else begin
         ref_sync_q <= {ref_sync_q[0], ref_clock_in};
         txc_sync_q <= {txc_sync_q[0], tx_input_clock};
         ref_prev_q <= ref_sync_q[1];
         txc_prev_q <= txc_sync_q[1];
         pin_meta_q <= '{ctrl: tx_char_ctrl, data: tx_char_in};
         pin_sync_q <= pin_meta_q;
      end
   end

   logic ref_rise;
   logic ref_fall;
   logic txc_rise;
   assign ref_rise = ref_sync_q[1] & ~ref_prev_q;
   assign ref_fall = ~ref_sync_q[1] & ref_prev_q;
   assign txc_rise = txc_sync_q[1] & ~txc_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // control register
   logic src_sel_q;
   logic rate_sel_q;
   logic half_rate_q;
   logic reinit_q;
   logic init_pulse;
   logic sync_pulse;
   logic wr_ctrl;

   assign wr_ctrl = wr_in && (addr_in == CTRL_ADDR);
   // a zero written to the reinit bit recentres
   assign init_pulse = wr_ctrl && !wdata_in[CTRL_REINIT_BIT];
   assign sync_pulse = wr_ctrl && wdata_in[CTRL_SYNC_BIT];

   // configuration latches
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         src_sel_q   <= SRC_SEL_RST;
         rate_sel_q  <= RATE_SEL_RST;
         half_rate_q <= HALF_RATE_RST;
         reinit_q    <= REINIT_RST;
      end else if (wr_ctrl) begin
         src_sel_q   <= wdata_in[CTRL_SRC_BIT];
         rate_sel_q  <= wdata_in[CTRL_RATE_BIT];
         half_rate_q <= wdata_in[CTRL_HALF_BIT];
         reinit_q    <= wdata_in[CTRL_REINIT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // internal character clock and transmit clock output
   logic char_tick;
   // character clock derives from the reference only
   // half-rate mode ticks on both reference edges
   assign char_tick = ref_rise | (half_rate_q & ref_fall);

   logic [EDGE_CNT_W-1:0] edge_cnt_q;
   logic [EDGE_CNT_W-1:0] half_len_q;
   logic                  tx_clk_q;
   logic                  ref_edge;
   logic                  mid_point;

   assign ref_edge  = ref_rise | ref_fall;
   assign mid_point = (half_len_q > 8'h01) && (edge_cnt_q == (half_len_q >> 1));

   // measure reference half period, standing in for the transmit pll
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         edge_cnt_q <= EDGE_CNT_RST;
         half_len_q <= EDGE_CNT_RST;
      end else if (ref_edge) begin
         edge_cnt_q <= EDGE_CNT_W'(1);
         half_len_q <= edge_cnt_q;
      end else if (edge_cnt_q != '1) begin
         edge_cnt_q <= edge_cnt_q + EDGE_CNT_W'(1);
      end
   end

   // output toggles with the internal character clock edges
   // rate 1 adds a toggle at mid half period, doubling frequency
   // phase is only tied to the sampled edges, with sync latency
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         tx_clk_q <= 1'b0;
      end else if (!rate_sel_q) begin
         if (ref_rise) begin
            tx_clk_q <= 1'b1;
         end else if (ref_fall) begin
            tx_clk_q <= 1'b0;
         end
      end else if (ref_edge || mid_point) begin
         tx_clk_q <= ~tx_clk_q;
      end
   end
   assign tx_clock_out = tx_clk_q;

   ////////////////////////////////////////////////////////////////////////////
   // phase align buffer
   tx_char_s         buf_mem_q [BUF_DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [PTR_W-1:0] level;
   logic             buf_wr;
   logic             buf_rd;
   logic             overflow;
   logic             underflow;

   assign level = wr_ptr_q - rd_ptr_q;
   // host clock edges fill the buffer only with source select 0
   assign buf_wr    = !src_sel_q && txc_rise;
   assign buf_rd    = !src_sel_q && char_tick;
   // drift past capacity shows as a full write or an empty read
   assign overflow  = buf_wr && !buf_rd && (level == BUF_FULL);
   assign underflow = buf_rd && !buf_wr && (level == PTR_RST);

   // pointers restart half full so drift either way fits
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         wr_ptr_q <= BUF_CENTRE;
         rd_ptr_q <= PTR_RST;
      end else if (init_pulse) begin
         wr_ptr_q <= BUF_CENTRE;
         rd_ptr_q <= PTR_RST;
      end else begin
         // one write per read keeps the level near centre
         if (buf_wr && !overflow) begin
            wr_ptr_q <= wr_ptr_q + PTR_W'(1);
         end
         if (buf_rd && !underflow) begin
            rd_ptr_q <= rd_ptr_q + PTR_W'(1);
         end
      end
   end

   // buffer storage, one entry per generate slot
   for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_entry
      always_ff @(posedge clock_in) begin
         if (rst_in) begin
            buf_mem_q[i] <= CHAR_RST;
         end else if (buf_wr && !overflow && (wr_ptr_q[PTR_W-2:0] == (PTR_W-1)'(i))) begin
            // host character taken on its clock rising edge
            buf_mem_q[i] <= pin_sync_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // character output to the encoder
   tx_char_s char_q;
   logic     char_valid_q;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         char_q       <= CHAR_RST;
         char_valid_q <= 1'b0;
      end else begin
         char_valid_q <= char_tick;
         if (char_tick && src_sel_q) begin
            // reference clock captures pins, buffer bypassed
            // reference clock acts as interface clock
            char_q <= pin_sync_q;
         end else if (buf_rd && !underflow) begin
            // output refreshed on each character tick that does not underflow
            char_q <= buf_mem_q[rd_ptr_q[PTR_W-2:0]];
         end
      end
   end
   assign char_out       = char_q;
   assign char_valid_out = char_valid_q;

   ////////////////////////////////////////////////////////////////////////////
   // buffer state and path error
   buf_state_e state_q;
   logic       slip;
   assign slip = overflow | underflow;
   // recentring wins over a slip in the same cycle, since it discards the
   // buffer contents anyway; a slip wins over a word sync
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_q <= BUF_INIT;
      end else begin
         case (state_q)
            BUF_INIT: begin
               if (init_pulse) begin
                  state_q <= BUF_RUN;
               end
            end
            BUF_RUN: begin
               if (slip && !init_pulse) begin
                  state_q <= BUF_FAULT;
               end
            end
            BUF_FAULT: begin
               // cleared by recentring or word sync
               if (init_pulse || (sync_pulse && !slip)) begin
                  state_q <= BUF_RUN;
               end
            end
            default: begin
               state_q <= BUF_INIT;
            end
         endcase
      end
   end

   // low only once the buffer is initialized
   assign tx_path_error_out = (state_q != BUF_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // interrupts
   logic [IRQ_W-1:0] int_stat_q;
   logic [IRQ_W-1:0] int_mask_q;
   logic [IRQ_W-1:0] int_evt;

   assign int_evt[IRQ_ERR_BIT]  = (state_q == BUF_RUN) && slip && !init_pulse;
   assign int_evt[IRQ_INIT_BIT] = init_pulse;

   // write one to clear; a new event in the same cycle wins
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         int_stat_q <= IRQ_RST;
         int_mask_q <= IRQ_RST;
      end else begin
         if (wr_in && (addr_in == INT_STAT_ADDR)) begin
            int_stat_q <= (int_stat_q & ~wdata_in[IRQ_W-1:0]) | int_evt;
         end else begin
            int_stat_q <= int_stat_q | int_evt;
         end
         if (wr_in && (addr_in == INT_MASK_ADDR)) begin
            int_mask_q <= wdata_in[IRQ_W-1:0];
         end
      end
   end
   assign irq_out = |(int_stat_q & int_mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // register read port
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   // unmapped addresses read zero
   always_comb begin
      rdata_d = '0;
      case (addr_in)
         CTRL_ADDR: begin
            rdata_d[CTRL_SRC_BIT]    = src_sel_q;
            rdata_d[CTRL_RATE_BIT]   = rate_sel_q;
            rdata_d[CTRL_HALF_BIT]   = half_rate_q;
            rdata_d[CTRL_REINIT_BIT] = reinit_q;
         end
         STATUS_ADDR: begin
            rdata_d[STAT_ERR_BIT] = tx_path_error_out;
            rdata_d[STAT_LVL_LSB +: PTR_W] = level;
         end
         CHAR_ADDR: begin
            rdata_d[9:0] = char_q;
         end
         INT_STAT_ADDR: begin
            rdata_d[IRQ_W-1:0] = int_stat_q;
         end
         INT_MASK_ADDR: begin
            rdata_d[IRQ_W-1:0] = int_mask_q;
         end
         default: begin
            rdata_d = '0;
         end
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rd_in ? rdata_d : '0;
      end
   end
   assign rdata_out = rdata_q;

endmodule : tx_clock_phase_align

// ==== tx_align_pkg.sv ====
// shared constants and types of the transmit clock phase align block
package tx_align_pkg;

   // register bus geometry
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 32;

   // register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_ADDR     = 5'h00;
   localparam logic [ADDR_W-1:0] STATUS_ADDR   = 5'h04;
   localparam logic [ADDR_W-1:0] CHAR_ADDR     = 5'h08;
   localparam logic [ADDR_W-1:0] INT_STAT_ADDR = 5'h0c;
   localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 5'h10;

   // control register fields
   localparam int unsigned CTRL_SRC_BIT    = 0;
   localparam int unsigned CTRL_RATE_BIT   = 1;
   localparam int unsigned CTRL_HALF_BIT   = 2;
   localparam int unsigned CTRL_REINIT_BIT = 3;
   localparam int unsigned CTRL_SYNC_BIT   = 4;

   // control register reset values
   localparam logic SRC_SEL_RST = 1'b0;
   localparam logic RATE_SEL_RST = 1'b0;
   localparam logic HALF_RATE_RST = 1'b0;
   localparam logic REINIT_RST = 1'b1;

   // status register fields
   localparam int unsigned STAT_ERR_BIT = 0;
   localparam int unsigned STAT_LVL_LSB = 1;

   // interrupt bits
   localparam int unsigned IRQ_W        = 2;
   localparam int unsigned IRQ_ERR_BIT  = 0;
   localparam int unsigned IRQ_INIT_BIT = 1;
   localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

   // phase align buffer shape
   localparam int unsigned BUF_DEPTH = 4;
   localparam int unsigned PTR_W     = 3;
   localparam logic [PTR_W-1:0] PTR_RST    = 3'h0;
   localparam logic [PTR_W-1:0] BUF_CENTRE = 3'h2;
   localparam logic [PTR_W-1:0] BUF_FULL   = 3'h4;

   // reference edge spacing counter
   localparam int unsigned EDGE_CNT_W = 8;
   localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_RST = 8'h00;

   // phase buffer state, gray along init -> run -> fault
   typedef enum logic [1:0] {
      BUF_INIT  = 2'b00,
      BUF_RUN   = 2'b01,
      BUF_FAULT = 2'b11
   } buf_state_e;

   // one transmit character with its control bits
   typedef struct packed {
      logic [1:0] ctrl;
      logic [7:0] data;
   } tx_char_s;

   localparam tx_char_s CHAR_RST = 10'h000;

endpackage : tx_align_pkg

// ==== tx_align_properties.sv ====
// port checker of the transmit clock phase align block
module tx_align_properties (
   input wire logic                            clock_in,
   input wire logic                            rst_in,
   input wire logic [tx_align_pkg::ADDR_W-1:0] addr_in,
   input wire logic [tx_align_pkg::DATA_W-1:0] wdata_in,
   input wire logic                            wr_in,
   input wire tx_align_pkg::tx_char_s          char_out,
   input wire logic                            char_valid_out,
   input wire logic                            tx_clock_out,
   input wire logic                            tx_path_error_out,
   input wire logic                            irq_out
);
   import tx_align_pkg::*;
   logic       rate_q;
   logic [1:0] mask_q;
   logic       ctrl_wr;

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   assign ctrl_wr = wr_in && addr_in == CTRL_ADDR;

   // mirror of rate select and irq mask, as software wrote them
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rate_q <= 1'b0;
         mask_q <= 2'h0;
      end else if (wr_in) begin
         if (addr_in == CTRL_ADDR) rate_q <= wdata_in[CTRL_RATE_BIT];
         if (addr_in == INT_MASK_ADDR) mask_q <= wdata_in[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ticks never closer than a ref half period
   property p_tick_gap;
      char_valid_out |=> !char_valid_out [*3];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
   property p_char_hold;
      !char_valid_out |-> $stable(char_out);
   endproperty
   a_char_hold: assert property (p_char_hold) else $error("char moved");
   // error drops only by a control write
   property p_err_fall;
      $fell(tx_path_error_out) |-> $past(wr_in) && $past(addr_in) == CTRL_ADDR;
   endproperty
   a_err_fall: assert property (p_err_fall) else $error("error dropped alone");
   property p_err_hold;
      tx_path_error_out && !ctrl_wr |=> tx_path_error_out;
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error not held");
   property p_init_clear;
      ctrl_wr && !wdata_in[CTRL_REINIT_BIT] |=> !tx_path_error_out;
   endproperty
   a_init_clear: assert property (p_init_clear) else $error("reinit ignored");
   // reference rate: high half a ref period
   property p_rate_ref;
      !rate_q && !$past(rate_q, 8) && !$past(rst_in, 8) && $rose(tx_clock_out) |->
         tx_clock_out [*4] ##1 !tx_clock_out;
   endproperty
   a_rate_ref: assert property (p_rate_ref) else $error("slow clock shape");
   // double rate: toggles every second cycle
   property p_rate_double;
      rate_q && $past(rate_q, 8) && $changed(tx_clock_out) |=>
         $stable(tx_clock_out) ##1 $changed(tx_clock_out);
   endproperty
   a_rate_double: assert property (p_rate_double) else $error("fast clock shape");
   // slip raises the interrupt when unmasked
   property p_slip_irq;
      $rose(tx_path_error_out) && mask_q[IRQ_ERR_BIT] |-> ##[0:1] irq_out;
   endproperty
   a_slip_irq: assert property (p_slip_irq) else $error("slip irq missing");
endmodule : tx_align_properties

bind tx_clock_phase_align tx_align_properties u_props (
   .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .char_out(char_out), .char_valid_out(char_valid_out),
   .tx_clock_out(tx_clock_out), .tx_path_error_out(tx_path_error_out), .irq_out(irq_out));

// ==== tx_host_model.sv ====
// host model: character clock and characters for the transmit path
module tx_host_model (
   input  wire logic       run_in,
   input  wire logic [7:0] base_in,
   output logic            clk_out,
   output logic [7:0]      data_out,
   output logic [1:0]      ctrl_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] cnt_q = 10'h000;

   // steady reference rate
   // parked low while stopped, which is how a slip is provoked
   initial clk_out = 1'b0;
   always begin
      #400;
      clk_out = run_in ? ~clk_out : 1'b0;
   end

   // data moves on falling edge
   // keeps the data still around the capturing rise
   always @(negedge clk_out) cnt_q <= cnt_q + 10'h001;
   assign data_out = base_in + cnt_q[7:0];
   assign ctrl_out = cnt_q[9:8];
endmodule : tx_host_model

// ==== tx_clock_phase_align_bench.sv ====
// self-checking bench of the transmit clock phase align block
module tx_clock_phase_align_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import tx_align_pkg::*;
   logic              clock_in = 1'b0;
   logic              rst_q, ref_q, wr_q, rd_q, run_q, mon_en, have_prev;
   logic              host_clk, valid, clk_out, err_out, irq;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q, rdata;
   logic [7:0]        base_q, host_data, prev;
   logic [1:0]        host_ctrl;
   tx_char_s          char_q;
   logic [9:0]        sent_q [$];
   int                err_total = 0, checks_done = 0, cycles = 0, seed = 32'hef7a;

   always #50 clock_in = ~clock_in;

   // reference clock, unrelated in phase to the system clock
   initial begin
      ref_q = 1'b0;
      #37;
      forever #400 ref_q = ~ref_q;
   end

   tx_clock_phase_align u_dut (
      .clock_in(clock_in), .rst_in(rst_q), .ref_clock_in(ref_q), .tx_input_clock(host_clk),
      .tx_char_in(host_data), .tx_char_ctrl(host_ctrl), .addr_in(addr_q),
      .wdata_in(wdata_q), .wr_in(wr_q), .rd_in(rd_q), .rdata_out(rdata), .char_out(char_q),
      .char_valid_out(valid), .tx_clock_out(clk_out), .tx_path_error_out(err_out),
      .irq_out(irq));
   tx_host_model u_host (.run_in(run_q), .base_in(base_q), .clk_out(host_clk),
      .data_out(host_data), .ctrl_out(host_ctrl));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock_in);
      addr_q <= a;
      wdata_q <= d;
      wr_q <= 1'b1;
      @(posedge clock_in);
      wr_q <= 1'b0;
      @(negedge clock_in);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clock_in);
      addr_q <= a;
      rd_q <= 1'b1;
      @(posedge clock_in);
      rd_q <= 1'b0;
      @(negedge clock_in);
      chk($sformatf("reg %h", a), rdata, exp);
   endtask : rd

   task automatic wait_n(input int n);
      repeat (n) @(negedge clock_in);
   endtask : wait_n

   // counts output clock rises and ticks over ten ref periods
   task automatic measure(input int n_clk, input int n_tick);
      int   c = 0;
      int   t = 0;
      logic last;
      last = clk_out;
      repeat (80) begin
         @(negedge clock_in);
         c += (clk_out === 1'b1 && last === 1'b0) ? 1 : 0;
         t += (valid === 1'b1) ? 1 : 0;
         last = clk_out;
      end
      chk("clock rises", c, n_clk);
      chk("ticks", t, n_tick);
   endtask : measure

   // stream order: each character one step above the last, and in host order
   always @(negedge clock_in) begin
      if (!mon_en) begin
         have_prev = 1'b0;
      end else if (valid === 1'b1) begin
         if (have_prev) begin
            chk("char order", char_q.data, 8'(prev + 8'h01));
            chk("char fifo", char_q, sent_q.pop_front());
         end else begin
            // align the model to the first character after a recentring
            while (sent_q.size() > 1 && sent_q[0] !== char_q) begin
               void'(sent_q.pop_front());
            end
            void'(sent_q.pop_front());
         end
         prev = char_q.data;
         have_prev = 1'b1;
      end
   end

   // model: characters the host shows at its clock rise, last eight kept
   always @(posedge host_clk) begin
      sent_q.push_back({host_ctrl, host_data});
      if (sent_q.size() > 8) begin
         void'(sent_q.pop_front());
      end
   end

   // hang guard, far above the expected run length
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 4000) begin
         err_total++;
         tally_and_finish();
      end
   end

   initial begin
      {rst_q, wr_q, rd_q, mon_en, run_q} = 5'h11;
      addr_q = '0;
      wdata_q = '0;
      base_q = 8'($random(seed));
      repeat (5) @(posedge clock_in);
      rst_q <= 1'b0;
      rd(CTRL_ADDR, 32'h8);
      rd(STATUS_ADDR, 32'h5);
      chk("error", err_out, 1);
      wr(5'h14, $random(seed));
      rd(5'h14, 32'h0);
      $display("test reset done");
      wr(INT_MASK_ADDR, 32'h3);
      wr(CTRL_ADDR, 32'h0);
      chk("error", err_out, 0);
      rd(INT_STAT_ADDR, 32'h2);
      chk("irq", irq, 1);
      wr(INT_STAT_ADDR, 32'h2);
      wait_n(2);
      chk("irq", irq, 0);
      wait_n(40);
      mon_en = 1'b1;
      measure(10, 10);
      wr(CTRL_ADDR, 32'ha);
      wait_n(10);
      measure(20, 10);
      wr(CTRL_ADDR, 32'h8);
      $display("test stream done");
      mon_en = 1'b0;
      run_q = 1'b0;
      wait_n(48);
      chk("error", err_out, 1);
      rd(INT_STAT_ADDR, 32'h1);
      wr(INT_MASK_ADDR, 32'h2);
      wait_n(2);
      chk("irq", irq, 0);
      wr(INT_MASK_ADDR, 32'h3);
      wait_n(2);
      chk("irq", irq, 1);
      run_q = 1'b1;
      wait_n(48);
      chk("error", err_out, 1);
      wr(CTRL_ADDR, 32'h18);
      chk("error", err_out, 0);
      wr(INT_STAT_ADDR, 32'h3);
      wr(CTRL_ADDR, 32'h0);
      wait_n(40);
      mon_en = 1'b1;
      wait_n(100);
      chk("error", err_out, 0);
      $display("test slip done");
      mon_en = 1'b0;
      run_q = 1'b0;
      wr(CTRL_ADDR, 32'h9);
      for (int i = 0; i < 3; i++) begin
         @(posedge clock_in);
         base_q <= 8'($random(seed));
         wait_n(24);
         chk("bypass char", char_q, {host_ctrl, host_data});
      end
      rd(CHAR_ADDR, {22'h0, host_ctrl, host_data});
      wr(CTRL_ADDR, 32'hd);
      wait_n(10);
      measure(10, 20);
      $display("test bypass done");
      tally_and_finish();
   end
endmodule : tx_clock_phase_align_bench
